/* File: logic/byte_memory.sv */
/*
 * Byte memory with bit-masked writes and registered read data.
 * Assumes one clock; the clock enable freezes reads and writes alike.
 */
`timescale 1ns/1ps
module byte_memory #(
   parameter int DEPTH = 256,
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic clk_en,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] wmask,
   output logic [7:0] rdata
);

   logic [7:0] mem [DEPTH];

   initial begin
      if (DEPTH != (1 << ADDR_W)) begin
         $error("byte_memory depth must equal two to the address width");
      end
   end

   // Masked writes let a single bit change without touching its neighbours.
   always_ff @(posedge clk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
         end
         if (rd_en) begin
            rdata <= mem[addr];
         end
      end
   end

endmodule

/* File: logic/memory_map_decoder.sv */
/*
 * Memory map decoder: region selects, peripheral frames, data EEPROM,
 * program memory, vector addresses and the reset vector fetch.
 * Assumes a CPU core on the same clock that issues one-cycle requests and
 * waits for ready, and zero-wait targets that answer on target_rdata.
 */
`timescale 1ns/1ps
`include "memory_map_decoder_regs.svh"
module memory_map_decoder
   import memory_map_decoder_pkg::*;
#(
   parameter bit PROGRAM_IS_EEPROM = 1'b0,
   parameter int SLOW_READ_CYCLES = `SLOW_READ_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_pdirect,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_index,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic cpu_ready,
   output logic cpu_busy,
   input wire logic bus_expansion,
   input wire logic mode_select_input,
   input wire logic vector_req,
   input wire logic vector_is_trap,
   input wire logic [3:0] vector_sel,
   output logic [15:0] vector_addr,
   output logic [7:0] pc_high_byte,
   output logic [7:0] pc_low_byte,
   output logic pc_loaded,
   output logic maker_space_hit,
   output logic protection_override_mode,
   output logic [7:0] data_eeprom_control,
   output logic [7:0] program_eeprom_control,
   output logic [7:0] block_write_protect,
   output logic [7:0] system_config_control0,
   output logic sel_register_file,
   output logic sel_peripheral,
   output logic [15:0] peripheral_frame_sel,
   output logic sel_external,
   output logic target_strobe,
   output logic target_we,
   output logic [15:0] target_addr,
   output logic [7:0] target_wdata,
   input wire logic [7:0] target_rdata
);

   initial begin
      if (SLOW_READ_CYCLES < 2 || SLOW_READ_CYCLES > 15) begin
         $error("SLOW_READ_CYCLES must lie between 2 and 15");
      end
   end

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic region_t decode(input logic [15:0] a, input logic expand);
      logic [3:0] frame;
      frame = a[7:4];
      if (a <= `RF_LAST) begin
         decode = R_RF;
      end else if (a >= `PF_BASE && a <= `PF_LAST) begin
         if (a == `SYS_CFG0_ADDR || a == `DEE_CTL_ADDR || a == `PEE_CTL_ADDR) begin
            decode = R_OWN;
         end else if (frame == `FRAME_TEST) begin
            decode = R_TEST;
         end else if (frame <= `FRAME_MOD_LAST) begin
            decode = R_PF;
         end else if (frame >= `FRAME_EXT_FIRST) begin
            decode = expand ? R_EXT : R_NONE;
         end else begin
            decode = R_NONE;
         end
      end else if (a == `WPROT_ADDR) begin
         decode = R_OWN;
      end else if (a >= `DEE_BASE && a <= `DEE_LAST) begin
         decode = R_DEE;
      end else if (a >= `PROG_BASE && a <= `PROG_LAST) begin
         decode = R_PROG;
      end else begin
         decode = expand ? R_EXT : R_NONE;
      end
   endfunction

   function automatic logic [15:0] vector_of(input logic trap, input logic [3:0] sel);
      if (trap) begin
         vector_of = `TRAP_BASE + {11'h000, sel, 1'b0};
      end else begin
         case (sel)
            4'h0: vector_of = `VEC_ADC;
            4'h1: vector_of = `VEC_TIMER2;
            4'h2: vector_of = `VEC_ASYNC_TX;
            4'h3: vector_of = `VEC_ASYNC_RX;
            4'h4: vector_of = `VEC_TIMER1;
            4'h5: vector_of = `VEC_SYNC;
            4'h6: vector_of = `VEC_INT3;
            4'h7: vector_of = `VEC_INT2;
            4'h8: vector_of = `VEC_INT1;
            default: vector_of = `VEC_RESET_HI;
         endcase
      end
   endfunction

   dec_state_t s;
   dec_state_t next_s;
   logic [15:0] eff_addr;
   region_t region;
   logic taken;
   logic slow_read;
   logic [7:0] wmask;
   logic [7:0] wbits;
   logic dee_blocked;
   logic dee_wr;
   logic prog_wr;
   logic mem_rd;
   logic [15:0] mem_addr;
   logic [7:0] dee_rdata;
   logic [7:0] prog_rdata;
   logic boot_rd;

   assign eff_addr = cpu_pdirect ? {`PF_HIGH, cpu_index} : cpu_addr;
   assign region = decode(eff_addr, bus_expansion);
   assign taken = clk_en && cpu_req && (s.state == S_IDLE);
   assign slow_read = taken && !cpu_we && (region == R_DEE || region == R_PROG);

   // ------------------------------------------------------------
   // Region selects toward the targets
   // ------------------------------------------------------------
   assign sel_register_file = taken && (region == R_RF);
   assign sel_peripheral = taken && (region == R_PF);
   assign sel_external = taken && (region == R_EXT);
   assign target_strobe = sel_register_file || sel_peripheral || sel_external;
   assign target_we = cpu_we;
   assign target_addr = eff_addr;
   assign target_wdata = cpu_wdata;

   genvar f;
   generate
      for (f = 0; f < 16; f++) begin : g_frame
         assign peripheral_frame_sel[f] = sel_peripheral && (eff_addr[7:4] == 4'(f));
      end
   endgenerate

   // ------------------------------------------------------------
   // EEPROM write qualification
   // ------------------------------------------------------------
   always_comb begin
      wbits = {8{cpu_wdata[`BIT_VALUE]}};
      wmask = 8'hff;
      if (region == R_DEE ? s.dee_ctl[`CTL_BIT_MODE] : s.pee_ctl[`CTL_BIT_MODE]) begin
         wmask = 8'h01 << cpu_wdata[2:0];
      end else begin
         wbits = cpu_wdata;
      end
   end

   assign dee_blocked = s.wprot[eff_addr[`DEE_BLOCK_MSB:`DEE_BLOCK_LSB]];
   assign dee_wr = taken && cpu_we && (region == R_DEE) && s.dee_ctl[`CTL_WRITE_EN] && !dee_blocked;
   assign prog_wr = taken && cpu_we && (region == R_PROG) && PROGRAM_IS_EEPROM
                    && s.pee_ctl[`CTL_WRITE_EN] && s.protection_override_mode;
   assign boot_rd = (s.state == S_BOOT_HI) || (s.state == S_BOOT_LO);
   assign mem_rd = slow_read || boot_rd;
   assign mem_addr = (s.state == S_BOOT_HI) ? `VEC_RESET_HI :
                     (s.state == S_BOOT_LO) ? `VEC_RESET_LO : eff_addr;

   // ------------------------------------------------------------
   // Arrays
   // ------------------------------------------------------------
   byte_memory #(
      .DEPTH(`DEE_DEPTH),
      .ADDR_W(8)
   ) u_data_eeprom (
      .clk(clk),
      .clk_en(clk_en),
      .rd_en(slow_read && region == R_DEE),
      .wr_en(dee_wr),
      .addr(mem_addr[7:0]),
      .wdata(wbits),
      .wmask(wmask),
      .rdata(dee_rdata)
   );

   byte_memory #(
      .DEPTH(`PROG_DEPTH),
      .ADDR_W(12)
   ) u_program (
      .clk(clk),
      .clk_en(clk_en),
      .rd_en(boot_rd || (slow_read && region == R_PROG)),
      .wr_en(prog_wr),
      .addr(mem_addr[11:0]),
      .wdata(wbits),
      .wmask(wmask),
      .rdata(prog_rdata)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.hv_sync = {s.hv_sync[1:0], mode_select_input};
      if (s.hv_sync[1] == s.hv_sync[2]) begin
         next_s.protection_override_mode = s.hv_sync[2];
      end
      if (vector_req) begin
         next_s.vector_addr = vector_of(vector_is_trap, vector_sel);
      end
      next_s.maker_space_hit = taken && eff_addr >= `MAKER_FIRST && eff_addr <= `MAKER_LAST;
      case (s.state)
         S_BOOT_HI: begin
            next_s.state = S_BOOT_HI_W;
         end
         S_BOOT_HI_W: begin
            next_s.pc_high_byte = prog_rdata;
            next_s.state = S_BOOT_LO;
         end
         S_BOOT_LO: begin
            next_s.state = S_BOOT_LO_W;
         end
         S_BOOT_LO_W: begin
            next_s.pc_low_byte = prog_rdata;
            next_s.state = S_IDLE;
         end
         S_IDLE: begin
            if (taken) begin
               next_s.state = S_RESP;
               next_s.rdata = `REG_RESET;
               if (slow_read) begin
                  next_s.state = S_WAIT;
                  next_s.wait_cnt = 4'h1;
                  next_s.slow_dee = (region == R_DEE);
               end else if (region == R_OWN) begin
                  case (eff_addr)
                     `SYS_CFG0_ADDR: begin
                        next_s.rdata = s.sys_cfg0;
                        if (cpu_we) next_s.sys_cfg0 = cpu_wdata;
                     end
                     `DEE_CTL_ADDR: begin
                        next_s.rdata = s.dee_ctl;
                        if (cpu_we) next_s.dee_ctl = cpu_wdata;
                     end
                     `PEE_CTL_ADDR: begin
                        next_s.rdata = s.pee_ctl;
                        if (cpu_we) next_s.pee_ctl = cpu_wdata;
                     end
                     default: begin
                        next_s.rdata = s.wprot;
                        if (cpu_we) next_s.wprot = cpu_wdata;
                     end
                  endcase
               end else if (target_strobe) begin
                  next_s.rdata = target_rdata;
               end
            end
         end
         S_WAIT: begin
            if (s.wait_cnt == 4'(SLOW_READ_CYCLES - 1)) begin
               next_s.rdata = s.slow_dee ? dee_rdata : prog_rdata;
               next_s.state = S_RESP;
            end else begin
               next_s.wait_cnt = s.wait_cnt + 4'h1;
            end
         end
         S_RESP: begin
            next_s.state = S_IDLE;
         end
         default: begin
            next_s.state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '{state: S_BOOT_HI, wait_cnt: 4'h0, rdata: `REG_RESET, sys_cfg0: `REG_RESET,
                dee_ctl: `REG_RESET, pee_ctl: `REG_RESET, wprot: `REG_RESET,
                pc_high_byte: 8'h00, pc_low_byte: 8'h00, hv_sync: 3'h0,
                protection_override_mode: 1'b0, vector_addr: `VEC_RESET_HI,
                maker_space_hit: 1'b0, slow_dee: 1'b0};
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cpu_rdata = s.rdata;
   assign cpu_ready = (s.state == S_RESP);
   assign cpu_busy = (s.state != S_IDLE);
   assign vector_addr = s.vector_addr;
   assign pc_high_byte = s.pc_high_byte;
   assign pc_low_byte = s.pc_low_byte;
   assign pc_loaded = !(boot_rd || s.state == S_BOOT_HI_W || s.state == S_BOOT_LO_W);
   assign maker_space_hit = s.maker_space_hit;
   assign protection_override_mode = s.protection_override_mode;
   assign data_eeprom_control = s.dee_ctl;
   assign program_eeprom_control = s.pee_ctl;
   assign block_write_protect = s.wprot;
   assign system_config_control0 = s.sys_cfg0;

endmodule

/* File: logic/memory_map_decoder_pkg.sv */
/*
 * Types of the memory map decoder: regions, states and the state record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package memory_map_decoder_pkg;

   typedef enum logic [7:0] {
      R_NONE = 8'h01,
      R_RF = 8'h02,
      R_TEST = 8'h04,
      R_PF = 8'h08,
      R_EXT = 8'h10,
      R_DEE = 8'h20,
      R_PROG = 8'h40,
      R_OWN = 8'h80
   } region_t;

   typedef enum logic [6:0] {
      S_BOOT_HI = 7'h01,
      S_BOOT_HI_W = 7'h02,
      S_BOOT_LO = 7'h04,
      S_BOOT_LO_W = 7'h08,
      S_IDLE = 7'h10,
      S_WAIT = 7'h20,
      S_RESP = 7'h40
   } state_t;

   typedef struct packed {
      state_t state;
      logic [3:0] wait_cnt;
      logic slow_dee;
      logic [7:0] rdata;
      logic [7:0] sys_cfg0;
      logic [7:0] dee_ctl;
      logic [7:0] pee_ctl;
      logic [7:0] wprot;
      logic [7:0] pc_high_byte;
      logic [7:0] pc_low_byte;
      logic [2:0] hv_sync;
      logic protection_override_mode;
      logic [15:0] vector_addr;
      logic maker_space_hit;
   } dec_state_t;

endpackage

/* File: logic/memory_map_decoder_regs.svh */
// Functional notes
// - Decode the 256-address peripheral window 1000h to 10FFh.
// - Sixteen frames of sixteen bytes; frame from bits 7:4, register from 3:0.
// - Peripheral-direct index is added to 1000h to form the address.
// - Frame 0 is factory test; accesses there return unpredictable data.
// - Frames 1 to 7 route to system, pins, sync serial, timers, async serial, ADC.
// - Frames 8 to 11 are reserved and select no module.
// - With bus expansion, frames 12 to 15 go to the external buses.
// - A 256-byte data EEPROM sits at 1F00h to 1FFFh.
// - The data EEPROM is 8 blocks of 32 bytes, each write-protectable.
// - Data EEPROM writes may be whole bytes or single bits.
// - A data EEPROM read takes two system clock cycles.
// - Data EEPROM writes are governed by registers at 101Ah and 1F00h.
// - Program memory spans 7000h to 7FFFh for reads and fetches.
// - Addresses 7FECh to 7FFFh hold two-byte interrupt and reset vectors.
// - Sixteen software traps fetch vectors from 7FC0h to 7FDFh.
// - Each interrupt source and reset has its own fixed vector address.
// - Every program ROM access takes two system clock cycles; the decoder answers program memory writes after one.
// - The EEPROM variant provides 4 kilobytes of program EEPROM at 7000h.
// - The program EEPROM control register sits at 101Ch.
// - Program EEPROM reads are normal reads; writes follow the data EEPROM sequence.
// - Program EEPROM writes need protection override, entered by high voltage.
// - After reset the PC high byte loads from 7FFEh, low byte from 7FFFh.
/*
 * Address map, register offsets, field positions and timing counts of the
 * memory map decoder. Assumes inclusion by bare name from design files.
 */
`ifndef MEMORY_MAP_DECODER_REGS_SVH
`define MEMORY_MAP_DECODER_REGS_SVH

// ------------------------------------------------------------
// Address regions
// ------------------------------------------------------------
`define RF_LAST 16'h00ff
`define PF_BASE 16'h1000
`define PF_LAST 16'h10ff
`define PF_HIGH 8'h10
`define DEE_BASE 16'h1f00
`define DEE_LAST 16'h1fff
`define PROG_BASE 16'h7000
`define PROG_LAST 16'h7fff
`define TRAP_BASE 16'h7fc0
`define MAKER_FIRST 16'h7fe0
`define MAKER_LAST 16'h7feb

// ------------------------------------------------------------
// Peripheral frames
// ------------------------------------------------------------
`define FRAME_TEST 4'h0
`define FRAME_MOD_LAST 4'h7
`define FRAME_EXT_FIRST 4'hc

// ------------------------------------------------------------
// Registers and fields
// ------------------------------------------------------------
`define SYS_CFG0_ADDR 16'h1010
`define DEE_CTL_ADDR 16'h101a
`define PEE_CTL_ADDR 16'h101c
`define WPROT_ADDR 16'h1f00
`define REG_RESET 8'h00
`define CTL_WRITE_EN 0
`define CTL_BIT_MODE 1
`define BIT_VALUE 3
`define DEE_BLOCK_MSB 7
`define DEE_BLOCK_LSB 5

// ------------------------------------------------------------
// Vectors
// ------------------------------------------------------------
`define VEC_ADC 16'h7fec
`define VEC_TIMER2 16'h7fee
`define VEC_ASYNC_TX 16'h7ff0
`define VEC_ASYNC_RX 16'h7ff2
`define VEC_TIMER1 16'h7ff4
`define VEC_SYNC 16'h7ff6
`define VEC_INT3 16'h7ff8
`define VEC_INT2 16'h7ffa
`define VEC_INT1 16'h7ffc
`define VEC_RESET_HI 16'h7ffe
`define VEC_RESET_LO 16'h7fff

// ------------------------------------------------------------
// Timing and array sizes
// ------------------------------------------------------------
`define SLOW_READ_CYCLES 2
`define RF_SIZE 256
`define DEE_DEPTH 256
`define PROG_DEPTH 4096

`endif

/* File: testbench/memory_map_decoder_sva.sv */
/*
 * Checker of the memory map decoder: region selects, frame routing,
 * answer latency, vector addresses and the data EEPROM control register.
 * Assumes it is bound to the decoder top module and sees only its ports.
 */
`timescale 1ns/1ps
module memory_map_decoder_chk #(
   parameter int SLOW_READ_CYCLES = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_pdirect,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_index,
   input wire logic [7:0] cpu_wdata,
   input wire logic cpu_ready,
   input wire logic cpu_busy,
   input wire logic bus_expansion,
   input wire logic vector_req,
   input wire logic vector_is_trap,
   input wire logic [3:0] vector_sel,
   input wire logic [15:0] vector_addr,
   input wire logic [7:0] data_eeprom_control,
   input wire logic sel_register_file,
   input wire logic sel_peripheral,
   input wire logic [15:0] peripheral_frame_sel,
   input wire logic sel_external,
   input wire logic target_strobe,
   input wire logic [15:0] target_addr
);
   // ---------------------------------------------
   // Helpers and assertions
   // ---------------------------------------------
   localparam int SLOW_M1 = SLOW_READ_CYCLES - 1;
   logic take;
   logic [15:0] eff;
   logic slow;
   logic fast;
   assign take = clk_en && cpu_req && !cpu_busy;
   assign eff = cpu_pdirect ? {8'h10, cpu_index} : cpu_addr;
   assign slow = !cpu_we && (eff[15:8] == 8'h1f || eff[15:12] == 4'h7) && eff != 16'h1f00;
   assign fast = cpu_we || !(eff[15:8] == 8'h1f || eff[15:12] == 4'h7);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence slow_done;
      ##1 !cpu_ready ##SLOW_M1 cpu_ready;
   endsequence
   one_select_a: assert property ($onehot0({sel_register_file, sel_peripheral, sel_external}))
      else $error("more than one region select");
   frame_route_a: assert property (sel_peripheral |-> target_addr[15:8] == 8'h10 &&
      target_addr[7:4] inside {[4'h1:4'h7]} && peripheral_frame_sel == (16'h0001 << target_addr[7:4]))
      else $error("peripheral frame select wrong");
   reserved_frame_a: assert property (take && (eff[15:4] == 12'h100 || eff[15:6] == 10'h042) |-> !target_strobe)
      else $error("reserved frame selected a target");
   external_frame_a: assert property (take && eff[15:6] == 10'h043 |-> sel_external == bus_expansion)
      else $error("external frame routing wrong");
   direct_index_a: assert property (take && cpu_pdirect && target_strobe |-> target_addr == {8'h10, cpu_index})
      else $error("direct index address wrong");
   slow_read_a: assert property (take && slow |-> slow_done)
      else $error("slow read latency wrong");
   fast_answer_a: assert property (take && fast |=> cpu_ready)
      else $error("fast access not answered next cycle");
   trap_vector_a: assert property (clk_en && vector_req && vector_is_trap |=>
      vector_addr == 16'h7fc0 + {11'h000, $past(vector_sel), 1'b0})
      else $error("trap vector address wrong");
   int_vector_a: assert property (clk_en && vector_req && !vector_is_trap && vector_sel < 4'h9 |=>
      vector_addr == 16'h7fec + {11'h000, $past(vector_sel), 1'b0})
      else $error("interrupt vector address wrong");
   dee_control_a: assert property (take && cpu_we && eff == 16'h101a |=> data_eeprom_control == $past(cpu_wdata))
      else $error("data EEPROM control not written");
endmodule

bind memory_map_decoder memory_map_decoder_chk #(.SLOW_READ_CYCLES(SLOW_READ_CYCLES)) chk_u (.clk, .rstn,
   .clk_en, .cpu_req, .cpu_we, .cpu_pdirect, .cpu_addr, .cpu_index, .cpu_wdata, .cpu_ready, .cpu_busy,
   .bus_expansion, .vector_req, .vector_is_trap, .vector_sel, .vector_addr, .data_eeprom_control,
   .sel_register_file, .sel_peripheral, .peripheral_frame_sel, .sel_external, .target_strobe, .target_addr);

/* File: testbench/periph_target.sv */
/*
 * Zero-wait target model for register file, peripheral and external space.
 * Assumes the decoder samples target_rdata on the edge that takes a request.
 */
`timescale 1ns/1ps
module periph_target (
   input wire logic clk,
   input wire logic target_strobe,
   input wire logic [15:0] target_addr,
   output logic [7:0] target_rdata
);
   // ---------------------------------------------
   // Answer logic
   // ---------------------------------------------
   logic [7:0] last = 8'h00;
   // When not selected the data toggles every cycle, so stale data is never mistaken for an answer.
   always_comb begin
      if (target_strobe) begin
         target_rdata = target_addr[7:0] ^ 8'h96;
      end else begin
         target_rdata = ~last;
      end
   end
   always_ff @(posedge clk) begin
      last <= target_rdata;
   end
endmodule

/* File: testbench/tb.sv */
/*
 * Self-checking testbench of the memory map decoder.
 * Assumes the decoder package, the target model and the bound checker.
 */
`timescale 1ns/1ps
module tb;
   // ---------------------------------------------
   // Signals, instances and shared tasks
   // ---------------------------------------------
   int error_cnt = 0;
   int samples_checked = 0;
   logic clk, rstn, clk_en, cpu_req, cpu_we, cpu_pdirect, bus_expansion, mode_select_input;
   logic vector_req, vector_is_trap, cpu_ready, cpu_busy, pc_loaded, protection_override_mode, target_strobe;
   logic [3:0] vector_sel;
   logic [15:0] cpu_addr, vector_addr, target_addr;
   logic [7:0] cpu_index, cpu_wdata, cpu_rdata, pc_high_byte, pc_low_byte, data_eeprom_control;
   logic [7:0] block_write_protect, target_rdata;
   memory_map_decoder #(.PROGRAM_IS_EEPROM(1'b1), .SLOW_READ_CYCLES(2)) dut_u (.clk, .rstn, .clk_en, .cpu_req,
      .cpu_we, .cpu_pdirect, .cpu_addr, .cpu_index, .cpu_wdata, .cpu_rdata, .cpu_ready, .cpu_busy, .bus_expansion,
      .mode_select_input, .vector_req, .vector_is_trap, .vector_sel, .vector_addr, .pc_high_byte, .pc_low_byte,
      .pc_loaded, .maker_space_hit(), .protection_override_mode, .data_eeprom_control, .program_eeprom_control(),
      .block_write_protect, .system_config_control0(), .sel_register_file(), .sel_peripheral(),
      .peripheral_frame_sel(), .sel_external(), .target_strobe, .target_we(), .target_addr, .target_wdata(),
      .target_rdata);
   periph_target tgt_u (.clk, .target_strobe, .target_addr, .target_rdata);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Starts and ends on a rising edge; ready is sampled at falling edges.
   task automatic acc(input logic we, input logic pd, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q, output int lat);
      cpu_we <= we;
      cpu_pdirect <= pd;
      cpu_addr <= pd ? 16'h7000 : a;
      cpu_index <= a[7:0];
      cpu_wdata <= d;
      cpu_req <= 1'b1;
      @(posedge clk);
      cpu_req <= 1'b0;
      lat = 0;
      @(negedge clk);
      while (cpu_ready !== 1'b1 && lat < 16) begin
         @(negedge clk);
         lat++;
      end
      q = cpu_rdata;
      @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      int lat;
      acc(1'b1, 1'b0, a, d, q, lat);
      chk($sformatf("write %h latency", a), 16'h0000, 16'(lat));
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input int lat_exp);
      logic [7:0] q;
      int lat;
      acc(1'b0, 1'b0, a, 8'h00, q, lat);
      chk($sformatf("read %h data", a), {8'h00, exp}, {8'h00, q});
      chk($sformatf("read %h latency", a), 16'(lat_exp), 16'(lat));
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge clk);
      while (cpu_busy !== 1'b0 && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk("pc loaded", 16'h0001, {15'h0000, pc_loaded});
      @(posedge clk);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_frames();
      logic [7:0] q;
      logic [7:0] exp;
      logic [15:0] a;
      int lat;
      for (int be = 0; be < 2; be++) begin
         bus_expansion <= be[0];
         for (int f = 0; f < 16; f++) begin
            a = 16'h1003 | 16'(f << 4);
            exp = ((f >= 1 && f <= 7) || (f >= 12 && be == 1)) ? (a[7:0] ^ 8'h96) : 8'h00;
            acc(1'b0, 1'b1, a, 8'h00, q, lat);
            chk($sformatf("frame %0d data", f), {8'h00, exp}, {8'h00, q});
            chk("frame latency", 16'h0000, 16'(lat));
         end
      end
      bus_expansion <= 1'b0;
      rd(16'h0005, 8'h93, 0);
      rd(16'h2000, 8'h00, 0);
      wr(16'h1010, 8'ha5);
      rd(16'h1010, 8'ha5, 0);
      $display("test frames done");
   endtask
   task automatic t_dee();
      wr(16'h101a, 8'h01);
      wr(16'h1f00, 8'h00);
      wr(16'h1f25, 8'h77);
      wr(16'h1f05, 8'h5a);
      wr(16'h1f00, 8'h02);
      chk("protect register", 16'h0002, {8'h00, block_write_protect});
      wr(16'h1f25, 8'h11);
      rd(16'h1f25, 8'h77, 1);
      wr(16'h101a, 8'h03);
      wr(16'h1f05, 8'h0c);
      wr(16'h1f05, 8'h01);
      rd(16'h1f05, 8'h58, 1);
      rd(16'h101a, 8'h03, 0);
      $display("test data eeprom done");
   endtask
   task automatic t_vec();
      logic [15:0] exp;
      for (int i = 0; i < 26; i++) begin
         vector_req <= 1'b1;
         vector_is_trap <= (i >= 10);
         vector_sel <= (i >= 10) ? 4'(i - 10) : 4'(i);
         exp = (i >= 10) ? 16'h7fc0 + 16'(2 * (i - 10)) : 16'h7fec + 16'(2 * i);
         @(posedge clk);
         vector_req <= 1'b0;
         @(negedge clk);
         chk($sformatf("vector %0d", i), exp, vector_addr);
         @(posedge clk);
      end
      $display("test vectors done");
   endtask
   task automatic t_prog();
      mode_select_input <= 1'b1;
      repeat (6) @(negedge clk);
      chk("override", 16'h0001, {15'h0000, protection_override_mode});
      @(posedge clk);
      wr(16'h101c, 8'h01);
      rd(16'h101c, 8'h01, 0);
      wr(16'h7ffe, 8'h70);
      wr(16'h7fff, 8'h12);
      wr(16'h7000, 8'h33);
      mode_select_input <= 1'b0;
      repeat (6) @(posedge clk);
      wr(16'h7000, 8'hcc);
      rd(16'h7000, 8'h33, 1);
      rd(16'h7ffe, 8'h70, 1);
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      wait_idle();
      chk("pc high", 16'h0070, {8'h00, pc_high_byte});
      chk("pc low", 16'h0012, {8'h00, pc_low_byte});
      chk("control after reset", 16'h0000, {8'h00, data_eeprom_control});
      $display("test program memory done");
   endtask
   // ---------------------------------------------
   // Sequence, watchdog and verdict
   // ---------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      cpu_req = 1'b0;
      cpu_we = 1'b0;
      cpu_pdirect = 1'b0;
      cpu_addr = 16'h0000;
      cpu_index = 8'h00;
      cpu_wdata = 8'h00;
      bus_expansion = 1'b0;
      mode_select_input = 1'b0;
      vector_req = 1'b0;
      vector_is_trap = 1'b0;
      vector_sel = 4'h0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      wait_idle();
      t_frames();
      t_dee();
      t_vec();
      t_prog();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("MISMATCH watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule
